/* File: src/bwa_pkg.sv */
// Purpose: Constants and types for the binary word arithmetic unit
// Assumes: 16-bit data words, opcodes as two-digit decimal codes
// Notes:   Status and interrupt offsets live here
package bwa_pkg;
  localparam int unsigned WORD_W   = 16;
  localparam int unsigned OPC_W    = 8;
  localparam int unsigned ADDR_W   = 4;
  // Operation codes, decimal instruction numbers
  localparam logic [7:0] OPC_BINARY_ADD = 8'd50;
  localparam logic [7:0] OPC_BINARY_SUB = 8'd51;
  localparam logic [7:0] OPC_BINARY_MUL = 8'd52;
  localparam logic [7:0] OPC_BINARY_DIV = 8'd53;
  localparam logic [7:0] OPC_COMPLEMENT = 8'd29;
  localparam logic [7:0] OPC_WORD_AND   = 8'd34;
  localparam logic [7:0] OPC_WORD_OR    = 8'd35;
  localparam logic [7:0] OPC_CLEAR_CARRY = 8'd41;
  localparam logic [7:0] OPC_SET_CARRY   = 8'd40;
  // Carry flag address in the special relay area
  localparam logic [15:0] CARRY_FLAG_ADDR = 16'd25504;
  // Register offsets
  localparam logic [3:0] REG_FLAGS    = 4'h0;
  localparam logic [3:0] REG_RESULT   = 4'h1;
  localparam logic [3:0] REG_RESULT_HI = 4'h2;
  localparam logic [3:0] REG_IRQ_STAT = 4'h3;
  localparam logic [3:0] REG_IRQ_EN   = 4'h4;
  localparam logic [3:0] REG_IRQ_CLR  = 4'h5;
  localparam logic [3:0] REG_OP_COUNT = 4'h6;
  // Flag bit positions
  localparam int unsigned FLAG_CARRY = 0;
  localparam int unsigned FLAG_ZERO  = 1;
  localparam int unsigned FLAG_ERROR = 2;
  localparam int unsigned FLAG_W     = 3;
  // Interrupt event bits
  localparam int unsigned EV_DONE  = 0;
  localparam int unsigned EV_ERROR = 1;
  localparam int unsigned EV_CARRY = 2;
  localparam int unsigned EV_W     = 3;
  localparam logic [15:0] WORD_ZERO = 16'h0000;
  localparam logic [15:0] WORD_ONES = 16'hFFFF;
  typedef enum logic [1:0] {
    ST_IDLE,
    ST_DIV,
    ST_DONE
  } bwa_state_t;
endpackage

/* File: src/bwa_divider.sv */
// Purpose: Serial restoring divider for 16-bit words
// Assumes: Start is one cycle, operands stable only at start
// Notes:   One quotient bit per cycle; zero divisor flagged, not run
`timescale 1ns/1ns
`default_nettype none
module bwa_divider
  import bwa_pkg::*;
#(
  parameter int unsigned W = WORD_W
) (
  input  wire logic         i_clk,
  input  wire logic         i_nrst,
  input  wire logic         i_start,
  input  wire logic [W-1:0] i_dividend,
  input  wire logic [W-1:0] i_divisor,
  output logic              o_done,
  output logic [W-1:0]      o_quotient,
  output logic [W-1:0]      o_remainder
);
  localparam int unsigned CW = $clog2(W + 1);
  localparam logic [CW-1:0] CNT_LAST = CW'(W - 1);

  logic [W-1:0]  rem_q;
  logic [W-1:0]  quo_q;
  logic [W-1:0]  dsr_q;
  logic [CW-1:0] cnt_q;
  logic          busy_q;
  logic          done_q;
  wire  [W:0]    trial   = {rem_q, quo_q[W-1]};
  wire  [W:0]    diff    = trial - {1'b0, dsr_q};
  wire           fits    = ~diff[W];
  wire  [W-1:0]  rem_nxt = fits ? diff[W-1:0] : trial[W-1:0];

  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      rem_q  <= '0;
      quo_q  <= '0;
      dsr_q  <= '0;
      cnt_q  <= '0;
      busy_q <= 1'b0;
      done_q <= 1'b0;
    end else begin
      done_q <= 1'b0;
      if (i_start) begin
        rem_q  <= '0;
        quo_q  <= i_dividend;
        dsr_q  <= i_divisor;
        cnt_q  <= '0;
        busy_q <= 1'b1;
      end else if (busy_q) begin
        rem_q <= rem_nxt;
        quo_q <= {quo_q[W-2:0], fits};
        cnt_q <= cnt_q + 1'b1;
        if (cnt_q == CNT_LAST) begin
          busy_q <= 1'b0;
          done_q <= 1'b1;
        end
      end
    end
  end

  assign o_done      = done_q;
  assign o_quotient  = quo_q;
  assign o_remainder = rem_q;
endmodule
`default_nettype wire

/* File: src/bwa_alu.sv */
// Purpose: Binary word arithmetic and logic unit with flags
// Assumes: Sequencer holds request until o_READY, operands fetched
// Notes:   Divide takes 17 extra cycles; others finish in one
`timescale 1ns/1ns
`default_nettype none
// Operation
// - Condition low: nothing written, no flags change
// - Decode opcodes 50,51,52,53,29,34,35
// - Add augend, addend and carry
// - Carry set when sum exceeds FFFF
// - Carry held as status bit 25504
// - Subtract subtrahend and carry from minuend
// - Negative result sets carry, two's complement
// - Multiply gives 32-bit product, two words
// - Divide: quotient first word, remainder next
// - Complement inverts every operand bit
// - Bitwise AND of two input words
// - Zero flag follows result of each operation
// - Error flag on missing indirect operand
module bwa_alu
  import bwa_pkg::*;
#(
  parameter int unsigned W = WORD_W
) (
  input  wire logic              I_CLK,
  input  wire logic              I_NRST,
  input  wire logic              i_EXEC_VALID,
  input  wire logic              i_EXEC_COND,
  input  wire logic [OPC_W-1:0]  i_OPCODE,
  input  wire logic [W-1:0]      i_FIRST_INPUT_WORD,
  input  wire logic [W-1:0]      i_SECOND_INPUT_WORD,
  input  wire logic              i_OPERAND_MISSING,
  output logic                   o_READY,
  output logic                   o_WB_VALID,
  output logic                   o_WB_DOUBLE,
  output logic [W-1:0]           o_RESULT_WORD,
  output logic [W-1:0]           o_RESULT_NEXT_WORD,
  output logic                   o_CARRY_FLAG,
  output logic                   o_ZERO_FLAG,
  output logic                   o_ERROR_FLAG,
  input  wire logic [ADDR_W-1:0] i_REG_ADDR,
  input  wire logic [W-1:0]      i_REG_WDATA,
  input  wire logic              i_REG_WR,
  input  wire logic              i_REG_RD,
  output logic [W-1:0]           o_REG_RDATA,
  output logic                   o_IRQ
);
  bwa_state_t    state_q;
  logic          carry_q;
  logic          zero_q;
  logic          error_q;
  logic [W-1:0]  res_q;
  logic [W-1:0]  res_hi_q;
  logic          wb_valid_q;
  logic          wb_double_q;
  logic [EV_W-1:0] irq_stat_q;
  logic [EV_W-1:0] irq_en_q;
  logic [W-1:0]  op_count_q;
  logic [W-1:0]  rdata_q;

  // Decode
  wire take    = i_EXEC_VALID && (state_q == ST_IDLE);
  wire run     = take && i_EXEC_COND;
  wire is_add  = (i_OPCODE == OPC_BINARY_ADD);
  wire is_sub  = (i_OPCODE == OPC_BINARY_SUB);
  wire is_mul  = (i_OPCODE == OPC_BINARY_MUL);
  wire is_div  = (i_OPCODE == OPC_BINARY_DIV);
  wire is_com  = (i_OPCODE == OPC_COMPLEMENT);
  wire is_and  = (i_OPCODE == OPC_WORD_AND);
  wire is_or   = (i_OPCODE == OPC_WORD_OR);
  wire is_clc  = (i_OPCODE == OPC_CLEAR_CARRY);
  wire is_stc  = (i_OPCODE == OPC_SET_CARRY);
  wire known   = is_add | is_sub | is_mul | is_div | is_com | is_and | is_or;

  // Datapath
  wire [W:0]     add_sum = {1'b0, i_FIRST_INPUT_WORD} + {1'b0, i_SECOND_INPUT_WORD}
                           + {{W{1'b0}}, carry_q};
  wire [W:0]     sub_dif = {1'b0, i_FIRST_INPUT_WORD} - {1'b0, i_SECOND_INPUT_WORD}
                           - {{W{1'b0}}, carry_q};
  // Borrow out wraps to two's complement in the low word
  wire [W-1:0]   sub_res = sub_dif[W-1:0];
  wire [2*W-1:0] mul_res = i_FIRST_INPUT_WORD * i_SECOND_INPUT_WORD;
  wire [W-1:0]   com_res = ~i_FIRST_INPUT_WORD;
  wire [W-1:0]   and_res = i_FIRST_INPUT_WORD & i_SECOND_INPUT_WORD;
  wire [W-1:0]   or_res  = i_FIRST_INPUT_WORD | i_SECOND_INPUT_WORD;
  wire           div_zero = (i_SECOND_INPUT_WORD == WORD_ZERO);
  wire           bad_op  = i_OPERAND_MISSING;

  wire [W-1:0]   lo_res  = is_add ? add_sum[W-1:0] :
                           is_sub ? sub_res :
                           is_mul ? mul_res[W-1:0] :
                           is_com ? com_res :
                           is_and ? and_res : or_res;
  wire [W-1:0]   hi_res  = mul_res[2*W-1:W];
  wire           one_cyc = run && known && !is_div && !bad_op;
  wire           div_go  = run && is_div && !bad_op && !div_zero;
  wire           err_now = run && known && (bad_op || (is_div && div_zero));
  wire           lo_zero = (lo_res == WORD_ZERO);
  wire           mul_zero = lo_zero && (hi_res == WORD_ZERO);
  wire           res_zero = is_mul ? mul_zero : lo_zero;
  wire           carry_upd = one_cyc && (is_add || is_sub);
  wire           carry_nxt = is_add ? add_sum[W] : sub_dif[W];

  logic          div_done;
  logic [W-1:0]  div_quo;
  logic [W-1:0]  div_rem;

  bwa_divider #(
    .W (W)
  ) u_div (
    .i_clk       (I_CLK),
    .i_nrst      (I_NRST),
    .i_start     (div_go),
    .i_dividend  (i_FIRST_INPUT_WORD),
    .i_divisor   (i_SECOND_INPUT_WORD),
    .o_done      (div_done),
    .o_quotient  (div_quo),
    .o_remainder (div_rem)
  );

  wire div_zero_res = (div_quo == WORD_ZERO) && (div_rem == WORD_ZERO);

  // Events for interrupt status; set wins over clear
  wire [EV_W-1:0] ev_set;
  assign ev_set[EV_DONE]  = one_cyc || div_done;
  assign ev_set[EV_ERROR] = err_now;
  assign ev_set[EV_CARRY] = carry_upd && carry_nxt;

  wire wr_stat = i_REG_WR && (i_REG_ADDR == REG_FLAGS);
  wire wr_en   = i_REG_WR && (i_REG_ADDR == REG_IRQ_EN);
  wire wr_clr  = i_REG_WR && (i_REG_ADDR == REG_IRQ_CLR);
  wire [EV_W-1:0] clr_mask = wr_clr ? i_REG_WDATA[EV_W-1:0] : '0;

  // Flags and results
  always_ff @(posedge I_CLK or negedge I_NRST) begin
    if (!I_NRST) begin
      state_q     <= ST_IDLE;
      carry_q     <= 1'b0;
      zero_q      <= 1'b0;
      error_q     <= 1'b0;
      res_q       <= '0;
      res_hi_q    <= '0;
      wb_valid_q  <= 1'b0;
      wb_double_q <= 1'b0;
    end else begin
      wb_valid_q <= 1'b0;
      unique case (state_q)
        ST_IDLE: begin
          if (run && is_clc) begin
            carry_q <= 1'b0;
          end else if (run && is_stc) begin
            carry_q <= 1'b1;
          end
          if (one_cyc) begin
            res_q       <= lo_res;
            res_hi_q    <= hi_res;
            zero_q      <= res_zero;
            error_q     <= 1'b0;
            wb_valid_q  <= 1'b1;
            wb_double_q <= is_mul;
          end
          if (carry_upd) begin
            carry_q <= carry_nxt;
          end
          if (err_now) begin
            error_q <= 1'b1;
          end
          if (div_go) begin
            state_q <= ST_DIV;
          end
        end
        ST_DIV: begin
          if (div_done) begin
            res_q       <= div_quo;
            res_hi_q    <= div_rem;
            zero_q      <= div_zero_res;
            error_q     <= 1'b0;
            wb_valid_q  <= 1'b1;
            wb_double_q <= 1'b1;
            state_q     <= ST_DONE;
          end
        end
        ST_DONE: begin
          state_q <= ST_IDLE;
        end
      endcase
      if (wr_stat) begin
        carry_q <= i_REG_WDATA[FLAG_CARRY];
      end
    end
  end

  // Interrupts and register file
  always_ff @(posedge I_CLK or negedge I_NRST) begin
    if (!I_NRST) begin
      irq_stat_q <= '0;
      irq_en_q   <= '0;
      op_count_q <= '0;
    end else begin
      irq_stat_q <= (irq_stat_q & ~clr_mask) | ev_set;
      if (wr_en) begin
        irq_en_q <= i_REG_WDATA[EV_W-1:0];
      end
      if (ev_set[EV_DONE]) begin
        op_count_q <= op_count_q + 1'b1;
      end
    end
  end

  logic [W-1:0] rd_mux;
  always_comb begin
    rd_mux = '0;
    unique case (i_REG_ADDR)
      REG_FLAGS:     rd_mux = W'({error_q, zero_q, carry_q});
      REG_RESULT:    rd_mux = res_q;
      REG_RESULT_HI: rd_mux = res_hi_q;
      REG_IRQ_STAT:  rd_mux = W'(irq_stat_q);
      REG_IRQ_EN:    rd_mux = W'(irq_en_q);
      REG_OP_COUNT:  rd_mux = op_count_q;
      default:       rd_mux = '0;
    endcase
  end

  always_ff @(posedge I_CLK or negedge I_NRST) begin
    if (!I_NRST) begin
      rdata_q <= '0;
    end else begin
      rdata_q <= i_REG_RD ? rd_mux : '0;
    end
  end

  // Divider busy stalls the sequencer, no queueing
  assign o_READY            = (state_q == ST_IDLE);
  assign o_WB_VALID         = wb_valid_q;
  assign o_WB_DOUBLE        = wb_double_q;
  assign o_RESULT_WORD      = res_q;
  assign o_RESULT_NEXT_WORD = res_hi_q;
  assign o_CARRY_FLAG       = carry_q;
  assign o_ZERO_FLAG        = zero_q;
  assign o_ERROR_FLAG       = error_q;
  assign o_REG_RDATA        = rdata_q;
  assign o_IRQ              = |(irq_stat_q & irq_en_q);
endmodule
`default_nettype wire

/* File: testbench/bwa_alu_properties.sv */
// Purpose: Port assertions for the word ALU
// Assumes: Divide answers 18 cycles after it is taken
// Notes:   Bound into bwa_alu below
`timescale 1ns/1ns
`default_nettype none
module bwa_alu_properties
  import bwa_pkg::*;
(
  input wire logic              I_CLK,
  input wire logic              I_NRST,
  input wire logic              i_EXEC_VALID,
  input wire logic              i_EXEC_COND,
  input wire logic [OPC_W-1:0]  i_OPCODE,
  input wire logic [WORD_W-1:0] i_FIRST_INPUT_WORD,
  input wire logic [WORD_W-1:0] i_SECOND_INPUT_WORD,
  input wire logic              i_OPERAND_MISSING,
  input wire logic              o_READY,
  input wire logic              o_WB_VALID,
  input wire logic              o_WB_DOUBLE,
  input wire logic [WORD_W-1:0] o_RESULT_WORD,
  input wire logic [WORD_W-1:0] o_RESULT_NEXT_WORD,
  input wire logic              o_CARRY_FLAG,
  input wire logic              o_ZERO_FLAG,
  input wire logic              o_ERROR_FLAG
);
  wire [15:0] a = i_FIRST_INPUT_WORD;
  wire [15:0] b = i_SECOND_INPUT_WORD;
  wire [7:0]  op = i_OPCODE;
  wire        rq = o_READY & i_EXEC_VALID & i_EXEC_COND;
  wire        go = rq & ~i_OPERAND_MISSING;
  default clocking @(posedge I_CLK); endclocking
  default disable iff (!I_NRST);
  add_sum_a: assert property (
    go && op == OPC_BINARY_ADD |=> o_WB_VALID &&
    {o_CARRY_FLAG, o_RESULT_WORD} == $past({1'b0, a} + b + o_CARRY_FLAG))
    else $error("add sum or carry wrong");
  sub_diff_a: assert property (
    go && op == OPC_BINARY_SUB |=> o_WB_VALID &&
    {o_CARRY_FLAG, o_RESULT_WORD} == $past({1'b0, a} - b - o_CARRY_FLAG))
    else $error("subtract result or borrow wrong");
  mul_prod_a: assert property (
    go && op == OPC_BINARY_MUL |=> o_WB_DOUBLE &&
    {o_RESULT_NEXT_WORD, o_RESULT_WORD} == $past({16'h0000, a} * {16'h0000, b}))
    else $error("product words wrong");
  div_quot_a: assert property (
    go && op == OPC_BINARY_DIV && b != WORD_ZERO |-> ##18 o_WB_VALID &&
    o_RESULT_WORD == $past(a, 18) / $past(b, 18) &&
    o_RESULT_NEXT_WORD == $past(a, 18) % $past(b, 18))
    else $error("quotient or remainder wrong");
  div_zero_a: assert property (
    go && op == OPC_BINARY_DIV && b == WORD_ZERO |=> ##[0:1] o_ERROR_FLAG)
    else $error("zero divisor not flagged");
  com_inv_a: assert property (
    go && op == OPC_COMPLEMENT |=> o_RESULT_WORD == ~$past(a))
    else $error("complement wrong");
  and_word_a: assert property (
    go && op == OPC_WORD_AND |=> o_RESULT_WORD == ($past(a) & $past(b)))
    else $error("word and wrong");
  zero_flag_a: assert property (
    o_WB_VALID |-> o_ZERO_FLAG == (o_RESULT_WORD == WORD_ZERO &&
    (!o_WB_DOUBLE || o_RESULT_NEXT_WORD == WORD_ZERO)))
    else $error("zero flag wrong");
  nop_hold_a: assert property (
    o_READY && i_EXEC_VALID && !i_EXEC_COND |=> !o_WB_VALID &&
    $stable({o_CARRY_FLAG, o_ZERO_FLAG, o_ERROR_FLAG}))
    else $error("condition low changed state");
  miss_err_a: assert property (
    rq && i_OPERAND_MISSING && op == OPC_WORD_AND |=> o_ERROR_FLAG && !o_WB_VALID)
    else $error("missing operand not flagged");
  cover property (go && op == OPC_BINARY_DIV);
  cover property (o_WB_VALID && o_WB_DOUBLE);
  cover property (rq && i_OPERAND_MISSING);
endmodule
bind bwa_alu bwa_alu_properties chk (.*);
`default_nettype wire

/* File: testbench/bwa_seq_model.sv */
// Purpose: Instruction sequencer feeding operand words
// Assumes: Request held until taken on a ready edge
// Notes:   Released words turn inverted, never stale
`timescale 1ns/1ns
`default_nettype none
module bwa_seq_model
  import bwa_pkg::*;
(
  input  wire logic  i_clk,
  input  wire logic  i_ready,
  output logic       o_valid,
  output logic       o_cond,
  output logic [7:0] o_opcode,
  output logic [15:0] o_first,
  output logic [15:0] o_second,
  output logic       o_missing
);
  initial begin
    o_valid = 1'b0;
    o_cond = 1'b0;
    o_opcode = 8'h00;
    o_first = 16'h0000;
    o_second = 16'h0000;
    o_missing = 1'b0;
  end
  task automatic issue(input logic [7:0] op, input logic [15:0] a, b, input logic c, m);
    // Request goes up just after a rising edge so it is taken exactly once
    @(posedge i_clk);
    o_valid <= 1'b1;
    o_cond <= c;
    o_opcode <= op;
    o_first <= a;
    o_second <= b;
    o_missing <= m;
    // Ready only moves on rising edges, so its mid-cycle level is what the edge samples
    @(negedge i_clk);
    while (i_ready !== 1'b1) @(negedge i_clk);
    @(posedge i_clk);
    o_valid <= 1'b0;
    // Stale operands would hide a late capture
    o_first <= ~a;
    o_second <= ~b;
  endtask
endmodule
`default_nettype wire

/* File: testbench/bwa_alu_test.sv */
// Purpose: Self-checking bench for the word ALU
// Assumes: Sequencer model drives the exec side
// Notes:   Table rows first, odd cases after
`timescale 1ns/1ns
`default_nettype none
module bwa_alu_test
  import bwa_pkg::*;
();
  typedef struct {logic [7:0] op; logic [15:0] a, b; logic ci;
                  logic [15:0] r, n; logic c, z;} bwa_row_t;
  bwa_row_t rows [12] = '{
    '{OPC_BINARY_ADD, 16'hA6E2, 16'h80C5, 0, 16'h27A7, 16'h0000, 1, 0},
    '{OPC_BINARY_ADD, 16'hFFFF, 16'h0000, 1, 16'h0000, 16'h0000, 1, 1},
    '{OPC_BINARY_SUB, 16'h5A10, 16'h60E3, 0, 16'hF92D, 16'h0000, 1, 0},
    '{OPC_BINARY_SUB, 16'h0005, 16'h0004, 1, 16'h0000, 16'h0000, 0, 1},
    '{OPC_BINARY_MUL, 16'h1234, 16'h5678, 1, 16'h0060, 16'h0626, 1, 0},
    '{OPC_BINARY_MUL, 16'hFFFF, 16'hFFFF, 0, 16'h0001, 16'hFFFE, 0, 0},
    '{OPC_BINARY_DIV, 16'h3452, 16'h0003, 0, 16'h1170, 16'h0002, 0, 0},
    '{OPC_COMPLEMENT, 16'h0F0F, 16'h0000, 0, 16'hF0F0, 16'h0000, 0, 0},
    '{OPC_COMPLEMENT, 16'hFFFF, 16'h0000, 1, 16'h0000, 16'h0000, 1, 1},
    '{OPC_WORD_AND, 16'hF0F0, 16'h3C3C, 0, 16'h3030, 16'h0000, 0, 0},
    '{OPC_WORD_AND, 16'hF0F0, 16'h0F0F, 1, 16'h0000, 16'h0000, 1, 1},
    '{OPC_WORD_OR, 16'h1200, 16'h0034, 0, 16'h1234, 16'h0000, 0, 0}};
  logic        clk, nrst, wr, rd;
  logic [3:0]  ra;
  logic [15:0] wd;
  wire         valid, cond, miss, ready, wbv, wbd, carry, zero, err, irq;
  wire [7:0]   opc;
  wire [15:0]  fa, fb, res, nxt, rdat;
  int          fail_count, cmp_count;
  bwa_seq_model seq (.i_clk(clk), .i_ready(ready), .o_valid(valid), .o_cond(cond),
    .o_opcode(opc), .o_first(fa), .o_second(fb), .o_missing(miss));
  bwa_alu dut (.I_CLK(clk), .I_NRST(nrst), .i_EXEC_VALID(valid), .i_EXEC_COND(cond),
    .i_OPCODE(opc), .i_FIRST_INPUT_WORD(fa), .i_SECOND_INPUT_WORD(fb),
    .i_OPERAND_MISSING(miss), .o_READY(ready), .o_WB_VALID(wbv), .o_WB_DOUBLE(wbd),
    .o_RESULT_WORD(res), .o_RESULT_NEXT_WORD(nxt), .o_CARRY_FLAG(carry),
    .o_ZERO_FLAG(zero), .o_ERROR_FLAG(err), .i_REG_ADDR(ra), .i_REG_WDATA(wd),
    .i_REG_WR(wr), .i_REG_RD(rd), .o_REG_RDATA(rdat), .o_IRQ(irq));
  task automatic chk(input logic [16:0] got, exp);
    cmp_count++;
    if (got !== exp) begin
      fail_count++;
      $display("ERROR %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic close_out;
    $display("Compares %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic wait_wb;
    int n;
    n = 0;
    do begin @(negedge clk); n++; end while (wbv !== 1'b1 && n < 30);
    chk(wbv, 1'b1);
  endtask
  task automatic reg_wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk);
    ra <= a;
    wd <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    @(negedge clk);
  endtask
  task automatic reg_rd(input logic [3:0] a, input logic [15:0] exp);
    @(posedge clk);
    ra <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    @(negedge clk);
    chk(rdat, exp);
  endtask
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  // Whole run needs a little over a hundred cycles; this is far beyond
  initial begin
    #40000;
    fail_count++;
    close_out;
  end
  initial begin
    nrst = 1'b0; wr = 1'b0; rd = 1'b0; ra = 4'h0; wd = 16'h0000;
    fail_count = 0; cmp_count = 0;
    repeat (3) @(posedge clk);
    nrst <= 1'b1;
    @(negedge clk);
    chk({ready, carry, zero, err, wbv}, 5'h10);
    foreach (rows[i]) begin
      seq.issue(rows[i].ci ? OPC_SET_CARRY : OPC_CLEAR_CARRY, 0, 0, 1, 0);
      repeat (2) @(negedge clk);
      seq.issue(rows[i].op, rows[i].a, rows[i].b, 1'b1, 1'b0);
      wait_wb;
      chk(res, rows[i].r);
      chk(carry, rows[i].c);
      chk(zero, rows[i].z);
      chk(wbd, rows[i].op inside {OPC_BINARY_MUL, OPC_BINARY_DIV});
      if (wbd === 1'b1) chk(nxt, rows[i].n);
    end
    seq.issue(OPC_SET_CARRY, 0, 0, 1'b1, 1'b0);
    repeat (2) @(negedge clk);
    reg_rd(REG_FLAGS, 16'h0001);
    for (int k = 0; k < 2; k++) begin
      seq.issue(k ? 8'h63 : OPC_BINARY_ADD, 16'h1111, 16'h2222, k[0], 1'b0);
      repeat (3) begin @(negedge clk); chk(wbv, 1'b0); end
    end
    chk({res, carry}, {16'h1234, 1'b1});
    seq.issue(OPC_WORD_AND, 16'hFFFF, 16'h00FF, 1'b1, 1'b1);
    @(negedge clk);
    chk({err, res}, {1'b1, 16'h1234});
    reg_wr(REG_IRQ_CLR, 16'h0007);
    reg_wr(REG_IRQ_EN, 16'h0002);
    chk(irq, 1'b0);
    seq.issue(OPC_WORD_AND, 16'hFFFF, 16'h00FF, 1'b1, 1'b0);
    wait_wb;
    chk({err, res}, {1'b0, 16'h00FF});
    seq.issue(OPC_BINARY_DIV, 16'h0010, 16'h0000, 1'b1, 1'b0);
    repeat (2) @(negedge clk);
    chk({err, irq}, 2'h3);
    reg_wr(REG_IRQ_EN, 16'h0000);
    chk(irq, 1'b0);
    reg_wr(REG_IRQ_EN, 16'h0002);
    chk(irq, 1'b1);
    reg_wr(REG_IRQ_CLR, 16'h0002);
    chk(irq, 1'b0);
    reg_rd(REG_IRQ_EN, 16'h0002);
    reg_rd(4'hF, 16'h0000);
    close_out;
  end
endmodule
`default_nettype wire
